// [dv/iid_decode_chk.sv]
// Assertion checker for the instruction decode and timing block.
`timescale 1ns/1ps
`default_nettype none
module iid_decode_chk (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic in_ready,
  input wire logic done_ff,
  input wire logic [3:0] op_class_ff,
  input wire logic [5:0] flag_upd_ff,
  input wire logic [5:0] flag_clr_ff,
  input wire logic [5:0] flag_undef_ff,
  input wire logic op_mem_ff,
  input wire logic int5_ff,
  input wire logic undef_op_ff,
  input wire logic blit_buf0_pointer_rewind_ff,
  input wire logic blit_buf1_pointer_rewind_ff
);
  logic [6:0] run_ff;
  // Length of the stretch with in_ready low; seen beside done_ff it is the clock count.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) run_ff <= 7'h00;
    else run_ff <= in_ready ? 7'h00 : run_ff + 7'h01;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////
  property p_asc;
    done_ff && op_class_ff inside {4'h1, 4'h4} |->
      run_ff == 7'h03 && flag_upd_ff == 6'h05 && flag_undef_ff == 6'h3a;
  endproperty
  a_asc: assert property (p_asc) else $error("adjust after sum timing wrong");
  property p_div;
    done_ff && op_class_ff == 4'h2 |-> run_ff == 7'h07 && flag_upd_ff == 6'h1a;
  endproperty
  a_div: assert property (p_div) else $error("adjust before divide wrong");
  property p_mul;
    done_ff && op_class_ff == 4'h3 |-> run_ff == 7'h13 && flag_undef_ff == 6'h25;
  endproperty
  a_mul: assert property (p_mul) else $error("adjust after multiply wrong");
  property p_alu;
    done_ff && op_class_ff inside {4'h5, 4'h6} |-> run_ff == 7'h01 && flag_upd_ff == 6'h3f;
  endproperty
  a_alu: assert property (p_alu) else $error("add timing or flags wrong");
  property p_and;
    done_ff && op_class_ff == 4'h7 |-> run_ff == 7'h01 && flag_clr_ff == 6'h21
      && flag_upd_ff == 6'h1a && flag_undef_ff == 6'h04;
  endproperty
  a_and: assert property (p_and) else $error("logical and wrong");
  property p_adjust_requested_privilege;
    done_ff && op_class_ff == 4'h8 |-> run_ff == 7'h09 && flag_upd_ff == 6'h08 && !undef_op_ff;
  endproperty
  a_adjust_requested_privilege: assert property (p_adjust_requested_privilege) else $error("privilege adjust wrong");
  property p_blit;
    done_ff && op_class_ff inside {4'h9, 4'ha} |-> run_ff == 7'h02 && flag_upd_ff == 6'h00
      && blit_buf0_pointer_rewind_ff == (op_class_ff == 4'h9)
      && blit_buf1_pointer_rewind_ff == (op_class_ff == 4'ha);
  endproperty
  a_blit: assert property (p_blit) else $error("pointer rewind wrong");
  property p_bnd;
    done_ff && op_class_ff == 4'hb |-> run_ff == (int5_ff ? 7'h08 : 7'h07) && flag_upd_ff == 6'h00;
  endproperty
  a_bnd: assert property (p_bnd) else $error("bound check wrong");
  property p_bsf;
    done_ff && op_class_ff == 4'hc && !op_mem_ff |-> run_ff == 7'h04 && flag_upd_ff == 6'h08;
  endproperty
  a_bsf: assert property (p_bsf) else $error("bit scan wrong");
  property p_evt;
    int5_ff || blit_buf0_pointer_rewind_ff || blit_buf1_pointer_rewind_ff |-> done_ff;
  endproperty
  a_evt: assert property (p_evt) else $error("event pulse without done");
  property p_one;
    done_ff |=> !done_ff;
  endproperty
  a_one: assert property (p_one) else $error("done longer than one cycle");
endmodule // iid_decode_chk
bind iid_decode iid_decode_chk u_chk (.*);
`default_nettype wire

// [dv/iid_fetch_model.sv]
// Model of the instruction fetch stream that offers bytes to the decoder.
`timescale 1ns/1ps
`default_nettype none
module iid_fetch_model (
  input wire logic clk,
  input wire logic in_ready,
  output logic in_valid,
  output logic [7:0] in_byte
);
  initial begin
    in_valid = 1'b0;
    in_byte = 8'h5a;
  end
  ////////////////////////////////////////
  // Offer a byte and hold it until taken; the caller may chain bytes back to back.
  // Ready is read mid-cycle, so the edge that takes the byte is the one counted.
  task automatic put(input logic [7:0] b);
    logic ok;
    in_valid <= 1'b1;
    in_byte <= b;
    do begin
      @(negedge clk);
      ok = in_ready;
      @(posedge clk);
    end while (ok !== 1'b1);
  endtask
  // Idle lines invert so that a stale byte is never mistaken for a fresh one.
  task automatic idle();
    in_valid <= 1'b0;
    in_byte <= ~in_byte;
  endtask
endmodule // iid_fetch_model
`default_nettype wire

// [dv/integer_insn_decode_timing_tb.sv]
// Self-checking testbench for the instruction decode and timing block.
`timescale 1ns/1ps
`default_nettype none
module integer_insn_decode_timing_tb;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic prot_mode = 1'b0;
  logic bound_out_of_range = 1'b0;
  logic [5:0] bsf_scan_count = 6'h00;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  wire in_valid, in_ready, done_ff, int5_ff, undef_op_ff;
  wire [7:0] in_byte;
  wire [3:0] op_class_ff;
  wire [5:0] flag_upd_ff, flag_clr_ff, flag_undef_ff;
  wire op_width_ff, op_dir_ff, op_sext_ff, op_mem_ff, op_imm_ff;
  wire blit_buf0_pointer_rewind_ff, blit_buf1_pointer_rewind_ff;
  wire [31:0] reg_rdata_ff;
  int error_cnt = 0;
  int num_checks = 0;
  int cyc_cnt = 0;
  logic [3:0] pul;
  iid_decode DUT (.*);
  iid_fetch_model fm (.clk(clk), .in_ready(in_ready), .in_valid(in_valid), .in_byte(in_byte));
  always #50 clk = ~clk;
  ////////////////////////////////////////
  task automatic give_verdict();
    if (error_cnt == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask
  // A hang is cut short here so the run always reaches the verdict.
  always @(posedge clk) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      error_cnt++;
      give_verdict();
    end
  end
  // Send an instruction, count edges up to done, and compare count and class.
  task automatic ins(input logic [23:0] b, input int nb, input logic [3:0] cls, input int n);
    int k;
    for (k = 0; k < nb; k++) fm.put(b[23-8*k -: 8]);
    fm.idle();
    k = 0;
    // Outputs are read mid-cycle, away from the edge that launches them.
    do begin
      @(negedge clk);
      k++;
    end while (done_ff !== 1'b1 && k < 200);
    pul = {int5_ff, undef_op_ff, blit_buf1_pointer_rewind_ff, blit_buf0_pointer_rewind_ff};
    @(posedge clk);
    chk(k, n + 1);
    chk(op_class_ff, cls);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk(reg_rdata_ff, e);
    @(posedge clk);
  endtask
  ////////////////////////////////////////
  task automatic t_ascii();
    ins(24'h370000, 1, 4'h1, 3);
    chk(flag_upd_ff, 6'h05);
    chk(flag_undef_ff, 6'h3a);
    ins(24'h3f0000, 1, 4'h4, 3);
    ins(24'hd50a00, 2, 4'h2, 7);
    chk(flag_undef_ff, 6'h25);
    ins(24'hd40a00, 2, 4'h3, 19);
    chk(flag_upd_ff, 6'h1a);
  endtask
  // Register, memory, accumulator and group forms for add, add-with-carry and AND.
  task automatic t_alu();
    logic [3:0] cls;
    logic [5:0] upd;
    int i;
    for (i = 0; i < 3; i++) begin
      cls = (i == 0) ? 4'h6 : (i == 1) ? 4'h5 : 4'h7;
      upd = (i == 2) ? 6'h1a : 6'h3f;
      ins({i[3:0], 4'h3, 8'hc0, 8'h00}, 2, cls, 1);
      chk({flag_upd_ff, flag_clr_ff}, {upd, (i == 2) ? 6'h21 : 6'h00});
      chk({op_width_ff, op_dir_ff, op_mem_ff, op_imm_ff}, 4'hc);
      ins({i[3:0], 4'h0, 8'h45, 8'h00}, 2, cls, 1);
      chk({op_width_ff, op_dir_ff, op_mem_ff, flag_upd_ff}, {3'h1, upd});
      ins({i[3:0], 4'h5, 16'h0}, 1, cls, 1);
      chk({op_width_ff, op_imm_ff}, 2'h3);
      ins({8'h83, 2'h3, i[1:0], 1'b0, 3'h0, 8'h00}, 2, cls, 1);
      chk({op_sext_ff, op_imm_ff, op_width_ff}, 3'h7);
    end
  endtask
  task automatic t_special();
    prot_mode <= 1'b1;
    ins(24'h63c000, 2, 4'h8, 9);
    prot_mode <= 1'b0;
    ins(24'h63c000, 2, 4'hf, 1);
    chk(pul, 4'h4);
    ins(24'h0f3a00, 2, 4'h9, 2);
    chk({pul, flag_upd_ff}, {4'h1, 6'h00});
    ins(24'h0f3b00, 2, 4'ha, 2);
    chk(pul, 4'h2);
    bound_out_of_range <= 1'b1;
    ins(24'h62c000, 2, 4'hb, 8);
    chk({pul, flag_upd_ff}, {4'h8, 6'h00});
    bound_out_of_range <= 1'b0;
    ins(24'h62c000, 2, 4'hb, 7);
    chk(pul, 4'h0);
    bsf_scan_count <= 6'h05;
    ins(24'h0fbcc0, 3, 4'hc, 4);
    chk(flag_upd_ff, 6'h08);
    ins(24'h0fbc00, 3, 4'hc, 14);
  endtask
  // Retired count, unmapped read, and the enable bit refusing bytes.
  task automatic t_regs();
    rd(8'h00, 32'h1);
    wr(8'h08, 32'h0);
    ins(24'h370000, 1, 4'h1, 3);
    ins(24'h03c000, 2, 4'h6, 1);
    rd(8'h08, 32'h2);
    rd(8'h0c, 32'h0);
    wr(8'h00, 32'h0);
    @(posedge clk);
    chk(in_ready, 1'b0);
    wr(8'h00, 32'h1);
    rd(8'h00, 32'h1);
  endtask
  // A reset in mid-count must abandon the instruction cleanly.
  task automatic t_reset();
    fm.put(8'hd4);
    fm.put(8'h0a);
    fm.idle();
    repeat (5) @(posedge clk);
    rst_b <= 1'b0;
    @(posedge clk);
    chk({done_ff, in_ready, op_class_ff}, 6'h10);
    rst_b <= 1'b1;
    ins(24'h370000, 1, 4'h1, 3);
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    t_ascii();
    t_alu();
    t_special();
    t_regs();
    t_reset();
    give_verdict();
  end
endmodule // integer_insn_decode_timing_tb
`default_nettype wire

// [rtl/iid_decode.v]
// Opcode decoder and clock-count sequencer for one slice of the integer instruction set.
//
// Behaviour
// RQ1: Opcode 37 is ascii_adjust_after_sum, 3 clocks, updates AF CF, others undefined.
// RQ2: Bytes D5 0A are ascii_adjust_before_divide, 7 clocks, updates SF ZF PF.
// RQ3: Bytes D4 0A are ascii_adjust_after_multiply, 19 clocks, updates SF ZF PF.
// RQ4: Opcode 3F is ascii_adjust_after_subtract, 3 clocks, updates AF CF.
// RQ5: Nibble 1 with 00dw plus ModR/M is add-with-carry, 1 clock, six flags.
// RQ6: 80-83 with reg 010, or nibble 1 with 010w, is add-with-carry immediate.
// RQ7: Nibble 0 with 00dw plus ModR/M is add, 1 clock, six flags.
// RQ8: 80-83 with reg 000, or nibble 0 with 010w, is add immediate.
// RQ9: Nibble 2 with 00dw is AND: clears OF CF, updates SF ZF PF, AF undefined.
// RQ10: 80-83 with reg 100, or nibble 2 with 010w, is AND immediate.
// RQ11: Opcode 63 with ModR/M adjusts privilege, protected mode only, 9 clocks, ZF.
// RQ12: Bytes 0F 3A rewind blit buffer 0 pointer in 2 clocks, no flags.
// RQ13: Bytes 0F 3B rewind blit buffer 1 pointer in 2 clocks, no flags.
// RQ14: Opcode 62 out of range raises interrupt 5 after 8 clocks, no flags.
// RQ15: Opcode 62 in range completes in 7 clocks without interrupt.
// RQ16: Bytes 0F BC scan bits forward, ZF only, 4 clocks register, 9+n memory.
// RQ17: Opcode figures are hexadecimal; bracketed groups are binary bit fields.
// RQ18: Undefined flags may hold anything; they are reported, never relied upon.
// RQ19: Bit w picks width, d picks direction, s sign-extends the 8-bit immediate.
// RQ20: Memory forms of add, add-with-carry and AND take 1 clock, same flags.
//
// Strobed register access and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "iid_regs.vh"

module iid_decode (
  input wire clk,
  input wire rst_b,
  input wire in_valid,
  input wire [7:0] in_byte,
  output wire in_ready,
  input wire prot_mode,
  input wire bound_out_of_range,
  input wire [5:0] bsf_scan_count,
  output reg done_ff,
  output reg [3:0] op_class_ff,
  output reg [5:0] flag_upd_ff,
  output reg [5:0] flag_clr_ff,
  output reg [5:0] flag_undef_ff,
  output reg op_width_ff,
  output reg op_dir_ff,
  output reg op_sext_ff,
  output reg op_mem_ff,
  output reg op_imm_ff,
  output reg int5_ff,
  output reg undef_op_ff,
  output reg blit_buf0_pointer_rewind_ff,
  output reg blit_buf1_pointer_rewind_ff,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata_ff
);

  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_SECOND = 2'h1;
  localparam [1:0] ST_MODRM = 2'h2;
  localparam [1:0] ST_EXEC = 2'h3;

  reg [1:0] state_ff;
  reg [1:0] nxt_state;
  reg [6:0] cnt_ff;
  reg [6:0] nxt_cnt;
  reg [7:0] first_ff;
  reg [3:0] cls_ff;
  reg [3:0] nxt_cls;
  reg launch;
  reg [6:0] launch_cnt;
  reg launch_mem;
  reg launch_imm;
  reg launch_int5;
  reg ctrl_en_ff;
  reg [15:0] retired_ff;
  reg [5:0] upd;
  reg [5:0] clr;
  reg [5:0] und;
  reg pend_int5_ff;
  wire take;
  wire [1:0] modrm_mod;
  wire [2:0] modrm_reg;
  wire finish;

  // Bytes are only accepted while no instruction is timing out its clocks.
  assign in_ready = ctrl_en_ff && (state_ff != ST_EXEC);
  assign take = in_valid && in_ready;
  assign modrm_mod = in_byte[7:6];
  assign modrm_reg = in_byte[5:3];
  assign finish = (state_ff == ST_EXEC) && (cnt_ff == 7'h01);

  ////////////////////////////////////////////////////////////////////////////
  // Byte sequencer: first byte, second opcode byte, ModR/M, then clock count.
  always @* begin
    nxt_state = state_ff;
    nxt_cls = cls_ff;
    nxt_cnt = cnt_ff;
    launch = 1'b0;
    launch_cnt = `IID_CLK_UD;
    launch_mem = 1'b0;
    launch_imm = 1'b0;
    launch_int5 = 1'b0;
    case (state_ff)
      ST_IDLE: begin
        if (take) begin
          // Opcode bytes compare as hexadecimal; bracketed fields as bits.
          case (in_byte) // RQ17
            `IID_OP_AAA: begin
              nxt_cls = `IID_C_AAA; // RQ1
              launch = 1'b1;
              launch_cnt = `IID_CLK_AAA; // RQ1
            end
            `IID_OP_AAS: begin
              nxt_cls = `IID_C_AAS; // RQ4
              launch = 1'b1;
              launch_cnt = `IID_CLK_AAS; // RQ4
            end
            `IID_OP_AAM, `IID_OP_AAD, `IID_OP_ESC: begin
              nxt_state = ST_SECOND;
            end
            `IID_OP_BOUND: begin
              nxt_cls = `IID_C_BOUND;
              nxt_state = ST_MODRM;
            end
            `IID_OP_ADJUST_REQUESTED_PRIVILEGE: begin
              nxt_cls = `IID_C_ADJUST_REQUESTED_PRIVILEGE;
              nxt_state = ST_MODRM;
            end
            default: begin
              if ((in_byte[7:4] == `IID_NIB_GRP) && (in_byte[3:2] == 2'h0)) begin
                nxt_cls = `IID_C_NONE; // Group form: reg field chooses.
                nxt_state = ST_MODRM;
              end else if (in_byte[7:4] <= `IID_NIB_AND) begin
                nxt_cls = (in_byte[7:4] == `IID_NIB_ADD) ? `IID_C_ADD : // RQ7 RQ8
                          (in_byte[7:4] == `IID_NIB_ADC) ? `IID_C_ADC : // RQ5 RQ6
                          `IID_C_AND; // RQ9 RQ10
                if (in_byte[3:2] == 2'h0) begin
                  nxt_state = ST_MODRM;
                end else if (in_byte[3:1] == 3'h2) begin
                  // Accumulator immediate form needs no ModR/M byte.
                  launch = 1'b1; // RQ6 RQ8 RQ10
                  launch_cnt = `IID_CLK_ALU;
                  launch_imm = 1'b1;
                end else begin
                  nxt_cls = `IID_C_UD;
                  launch = 1'b1;
                end
              end else begin
                nxt_cls = `IID_C_UD;
                launch = 1'b1;
              end
            end
          endcase
        end
      end
      ST_SECOND: begin
        if (take) begin
          launch = 1'b1;
          nxt_cls = `IID_C_UD;
          if (first_ff == `IID_OP_ESC) begin
            if (in_byte == `IID_OP_BB0) begin
              nxt_cls = `IID_C_BB0; // RQ12
              launch_cnt = `IID_CLK_BB;
            end else if (in_byte == `IID_OP_BB1) begin
              nxt_cls = `IID_C_BB1; // RQ13
              launch_cnt = `IID_CLK_BB;
            end else if (in_byte == `IID_OP_BSF) begin
              nxt_cls = `IID_C_BSF; // RQ16
              launch = 1'b0;
              nxt_state = ST_MODRM;
            end
          end else if (in_byte == `IID_OP_BASE) begin
            if (first_ff == `IID_OP_AAD) begin
              nxt_cls = `IID_C_AAD; // RQ2
              launch_cnt = `IID_CLK_AAD;
            end else begin
              nxt_cls = `IID_C_AAM; // RQ3
              launch_cnt = `IID_CLK_AAM;
            end
          end
        end
      end
      ST_MODRM: begin
        if (take) begin
          launch = 1'b1;
          launch_mem = (modrm_mod != 2'h3); // RQ20
          case (cls_ff)
            `IID_C_NONE: begin
              launch_imm = 1'b1;
              launch_cnt = `IID_CLK_ALU;
              case (modrm_reg)
                `IID_GRP_ADD: nxt_cls = `IID_C_ADD; // RQ8
                `IID_GRP_ADC: nxt_cls = `IID_C_ADC; // RQ6
                `IID_GRP_AND: nxt_cls = `IID_C_AND; // RQ10
                default: nxt_cls = `IID_C_UD;
              endcase
            end
            `IID_C_ADJUST_REQUESTED_PRIVILEGE: begin
              // Outside protected mode the opcode is refused as undefined.
              nxt_cls = prot_mode ? `IID_C_ADJUST_REQUESTED_PRIVILEGE : `IID_C_UD; // RQ11
              launch_cnt = prot_mode ? `IID_CLK_ADJUST_REQUESTED_PRIVILEGE : `IID_CLK_UD; // RQ11
            end
            `IID_C_BOUND: begin
              launch_int5 = bound_out_of_range; // RQ14
              launch_cnt = bound_out_of_range ? `IID_CLK_BOUND_OUT :
                           `IID_CLK_BOUND_IN; // RQ14 RQ15
            end
            `IID_C_BSF: begin
              launch_cnt = launch_mem ? (`IID_CLK_BSF_MEM + {1'b0, bsf_scan_count}) :
                           `IID_CLK_BSF_REG; // RQ16
            end
            default: begin
              launch_cnt = `IID_CLK_ALU; // RQ5 RQ7 RQ9 RQ20
            end
          endcase
        end
      end
      ST_EXEC: begin
        nxt_cnt = cnt_ff - 7'h01;
        if (finish) begin
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
    if (launch) begin
      nxt_state = ST_EXEC;
      nxt_cnt = launch_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flag effect of the class being launched: update, clear and undefined.
  always @* begin
    upd = 6'h00;
    clr = 6'h00;
    und = 6'h00;
    case (nxt_cls)
      `IID_C_AAA, `IID_C_AAS: begin
        upd = 6'h05; // RQ1 RQ4
        und = 6'h3a; // RQ18
      end
      `IID_C_AAD, `IID_C_AAM: begin
        upd = 6'h1a; // RQ2 RQ3
        und = 6'h25; // RQ18
      end
      `IID_C_ADC, `IID_C_ADD: begin
        upd = 6'h3f; // RQ5 RQ7 RQ20
      end
      `IID_C_AND: begin
        upd = 6'h1a; // RQ9
        clr = 6'h21; // RQ9
        und = 6'h04; // RQ18
      end
      `IID_C_ADJUST_REQUESTED_PRIVILEGE, `IID_C_BSF: begin
        upd = 6'h08; // RQ11 RQ16
      end
      default: begin
        upd = 6'h00; // RQ12 RQ13 RQ14 RQ15
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State, decoded operation and completion pulses.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= ST_IDLE;
      cnt_ff <= 7'h00;
      first_ff <= 8'h00;
      cls_ff <= `IID_C_NONE;
      done_ff <= 1'b0;
      op_class_ff <= `IID_C_NONE;
      flag_upd_ff <= 6'h00;
      flag_clr_ff <= 6'h00;
      flag_undef_ff <= 6'h00;
      op_width_ff <= 1'b0;
      op_dir_ff <= 1'b0;
      op_sext_ff <= 1'b0;
      op_mem_ff <= 1'b0;
      op_imm_ff <= 1'b0;
      int5_ff <= 1'b0;
      undef_op_ff <= 1'b0;
      blit_buf0_pointer_rewind_ff <= 1'b0;
      blit_buf1_pointer_rewind_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      cls_ff <= nxt_cls;
      if (take && (state_ff == ST_IDLE)) begin
        first_ff <= in_byte;
      end
      // Results are latched at launch and stand until the next launch.
      if (launch) begin
        op_class_ff <= nxt_cls;
        flag_upd_ff <= upd;
        flag_clr_ff <= clr;
        flag_undef_ff <= und;
        op_mem_ff <= launch_mem;
        op_imm_ff <= launch_imm;
        op_width_ff <= first_ff[0]; // RQ19
        op_dir_ff <= first_ff[1] && !launch_imm; // RQ19
        op_sext_ff <= first_ff[1] && launch_imm && (first_ff[7:4] == `IID_NIB_GRP); // RQ19
        if (state_ff == ST_IDLE) begin
          op_width_ff <= in_byte[0]; // RQ19
          op_dir_ff <= 1'b0;
          op_sext_ff <= 1'b0;
        end
        int5_ff <= 1'b0;
      end
      if (launch_int5) begin
        int5_ff <= 1'b0;
      end
      // Pulses fire in the cycle after the last counted clock.
      done_ff <= finish;
      int5_ff <= finish && (op_class_ff == `IID_C_BOUND) && (cnt_ff == 7'h01) &&
                 pend_int5_ff; // RQ14
      undef_op_ff <= finish && (op_class_ff == `IID_C_UD);
      blit_buf0_pointer_rewind_ff <= finish && (op_class_ff == `IID_C_BB0); // RQ12
      blit_buf1_pointer_rewind_ff <= finish && (op_class_ff == `IID_C_BB1); // RQ13
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Out-of-range verdict held until the bound check retires.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pend_int5_ff <= 1'b0;
    end else if (launch) begin
      pend_int5_ff <= launch_int5; // RQ14 RQ15
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register port: control, status and retired count; unmapped reads zero.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_en_ff <= `IID_CTRL_RESET;
      retired_ff <= 16'h0000;
      reg_rdata_ff <= 32'h00000000;
    end else begin
      if (reg_wr && (reg_addr == `IID_ADDR_CTRL)) begin
        ctrl_en_ff <= reg_wdata[0];
      end
      // A write to the retired count clears it, but a retirement wins.
      if (finish) begin
        retired_ff <= retired_ff + 16'h0001;
      end else if (reg_wr && (reg_addr == `IID_ADDR_RETIRED)) begin
        retired_ff <= 16'h0000;
      end
      reg_rdata_ff <= 32'h00000000;
      if (reg_rd) begin
        case (reg_addr)
          `IID_ADDR_CTRL: reg_rdata_ff <= {31'h00000000, ctrl_en_ff};
          `IID_ADDR_STAT: reg_rdata_ff <= {24'h000000, state_ff, 2'h0, op_class_ff};
          `IID_ADDR_RETIRED: reg_rdata_ff <= {16'h0000, retired_ff};
          default: reg_rdata_ff <= 32'h00000000;
        endcase
      end
    end
  end

endmodule // iid_decode

`default_nettype wire

// [rtl/iid_regs.vh]
// Constants for the integer instruction decode and timing block.
`ifndef IID_REGS_VH
`define IID_REGS_VH
// Register offsets (byte addresses, one 32-bit word each).
`define IID_ADDR_CTRL 8'h00
`define IID_ADDR_STAT 8'h04
`define IID_ADDR_RETIRED 8'h08
`define IID_CTRL_RESET 1'h1
// Flag vector bit positions.
`define IID_F_OF 5
`define IID_F_SF 4
`define IID_F_ZF 3
`define IID_F_AF 2
`define IID_F_PF 1
`define IID_F_CF 0
// Opcode bytes.
`define IID_OP_AAA 8'h37
`define IID_OP_AAS 8'h3f
`define IID_OP_AAM 8'hd4
`define IID_OP_AAD 8'hd5
`define IID_OP_BASE 8'h0a
`define IID_OP_ESC 8'h0f
`define IID_OP_BB0 8'h3a
`define IID_OP_BB1 8'h3b
`define IID_OP_BSF 8'hbc
`define IID_OP_BOUND 8'h62
`define IID_OP_ADJUST_REQUESTED_PRIVILEGE 8'h63
`define IID_NIB_ADD 4'h0
`define IID_NIB_ADC 4'h1
`define IID_NIB_AND 4'h2
`define IID_NIB_GRP 4'h8
`define IID_GRP_ADD 3'h0
`define IID_GRP_ADC 3'h2
`define IID_GRP_AND 3'h4
// Instruction classes.
`define IID_C_NONE 4'h0
`define IID_C_AAA 4'h1
`define IID_C_AAD 4'h2
`define IID_C_AAM 4'h3
`define IID_C_AAS 4'h4
`define IID_C_ADC 4'h5
`define IID_C_ADD 4'h6
`define IID_C_AND 4'h7
`define IID_C_ADJUST_REQUESTED_PRIVILEGE 4'h8
`define IID_C_BB0 4'h9
`define IID_C_BB1 4'ha
`define IID_C_BOUND 4'hb
`define IID_C_BSF 4'hc
`define IID_C_UD 4'hf
// Clock counts.
`define IID_CLK_AAA 7'h03
`define IID_CLK_AAS 7'h03
`define IID_CLK_AAD 7'h07
`define IID_CLK_AAM 7'h13
`define IID_CLK_ALU 7'h01
`define IID_CLK_ADJUST_REQUESTED_PRIVILEGE 7'h09
`define IID_CLK_BB 7'h02
`define IID_CLK_BOUND_OUT 7'h08
`define IID_CLK_BOUND_IN 7'h07
`define IID_CLK_BSF_REG 7'h04
`define IID_CLK_BSF_MEM 7'h09
`define IID_CLK_UD 7'h01
`endif
